/* File: hdl/adc_port_pkg.sv */
// Constants and carrier types for the converter output port logic
`default_nettype none
package adc_port_pkg;
	localparam int RESULT_BITS = 16;
	// APB register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_RAW = 8'h04;
	localparam logic [7:0] ADDR_START = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	// Control register fields
	localparam int CTRL_BYTE_ORDER_BIT = 0;
	localparam int CTRL_CODING_BIT = 1;
	localparam int CTRL_FAST_BIT = 2;
	localparam int CTRL_RATE_BIT = 3;
	localparam int CTRL_IFACE_BIT = 4;
	localparam logic [4:0] CTRL_RESET = 5'h02;
	localparam logic [15:0] RAW_RESET = 16'h0000;
	localparam int START_GO_BIT = 0;
	// Status register fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_MODE_LSB = 1;
	localparam int STAT_STATE_LSB = 4;
	localparam int STAT_PENDING_BIT = 7;
	localparam int STAT_DIV_LSB = 8;
	localparam int STAT_CLKSRC_BIT = 10;
	localparam int STAT_TIMING_BIT = 11;
	localparam int STAT_POL_BIT = 12;
	localparam int STAT_RESULT_LSB = 16;
	// Dual-purpose data pins, index into d_in
	localparam int PIN_DIV0 = 2;
	localparam int PIN_DIV1 = 3;
	localparam int PIN_CLK_SRC = 4;
	localparam int PIN_POLARITY = 5;
	localparam int PIN_TIMING = 7;
	localparam logic [15:0] OE_SERIAL_MASK = 16'h0003;
	localparam logic [15:0] OE_PARALLEL_MASK = 16'hffff;
	localparam logic [7:0] PIN_LVL_RESET = 8'h40;
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int CONV_FAST_NS = 360;
	localparam int CONV_NORMAL_NS = 485;
	localparam int CONV_FAST_CYCLES = CONV_FAST_NS / CLK_PERIOD_NS;
	localparam int CONV_NORMAL_CYCLES = CONV_NORMAL_NS / CLK_PERIOD_NS;
	localparam int SCLK_MIN_NS_0 = 8;
	localparam int SCLK_MIN_NS_1 = 16;
	localparam int SCLK_MIN_NS_2 = 32;
	localparam int SCLK_MIN_NS_3 = 64;
	localparam int SCLK_HALF_0 = (SCLK_MIN_NS_0 + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
	localparam int SCLK_HALF_1 = (SCLK_MIN_NS_1 + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
	localparam int SCLK_HALF_2 = (SCLK_MIN_NS_2 + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
	localparam int SCLK_HALF_3 = (SCLK_MIN_NS_3 + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);

	typedef enum logic [2:0] {
		MODE_WIDEBAND = 3'b001,
		MODE_FAST = 3'b010,
		MODE_RATE_INDEP = 3'b100
	} conv_mode_t;

	typedef enum logic [2:0] {
		SER_IDLE = 3'b001,
		SER_MASTER = 3'b010,
		SER_SLAVE = 3'b100
	} ser_state_t;

	typedef struct packed {
		logic iface_serial;
		logic rate_indep;
		logic fast_mode;
		logic output_coding_select;
		logic byte_order_select;
	} port_cfg_t;

	typedef struct packed {
		logic frame_marker_polarity;
		logic read_timing_select;
		logic clock_source_select;
		logic [1:0] serial_clock_divider;
	} serial_cfg_t;
endpackage : adc_port_pkg
`default_nettype wire

/* File: hdl/pin_sync.sv */
// Three-stage synchroniser for asynchronous pin inputs
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q2,
	output logic [WIDTH-1:0] q3
);
	logic [WIDTH-1:0] q1;
	logic [WIDTH-1:0] next_q1;
	logic [WIDTH-1:0] next_q2;
	logic [WIDTH-1:0] next_q3;

	always_comb begin
		next_q1 = d;
		next_q2 = q1;
		next_q3 = q2;
	end

	// Reset to the idle pin levels, so no false edge follows reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q1 <= RESET_VALUE;
			q2 <= RESET_VALUE;
			q3 <= RESET_VALUE;
		end else begin
			q1 <= next_q1;
			q2 <= next_q2;
			q3 <= next_q3;
		end
	end
endmodule : pin_sync
`default_nettype wire

/* File: hdl/adc_output_port_config.sv */
// Output port configuration, coding and serial/parallel delivery of results
// Notes on behaviour
// - Byte order high: low byte on upper lanes, high byte on lower lanes.
// - Byte order low: low byte on lower lanes, high byte on upper lanes.
// - Coding select high: results in straight offset binary.
// - Coding select low: only the top bit inverted, giving twos complement.
// - Fast and rate-independent selects both high: wideband fastest mode.
// - Fast high, rate-independent low: fastest mode without wideband.
// - Both selects low: rate-independent mode, full accuracy at any rate.
// - Serial interface: some data pins form serial port, rest high impedance.
// - Parallel interface: results delivered on the parallel data bus.
// - The two lowest data bits stay outputs in every mode.
// - In parallel mode dual-purpose pins are result bits two to seven.
// - Master read-after-convert: divider pins slow the internal serial clock.
// - Other serial modes: divider pins high impedance and ignored.
// - Clock source low: device is master and drives its serial clock.
// - Clock source high: host clocks, gated by chip select; device follows.
// - Divider codes give minimum clock periods of 8, 16, 32, 64 ns.
// - Timing high: previous result during conversion; low: after completion.
// - Master frame marker active high when polarity low, else active low.
// - Slave: daisy input appears on serial output after 16 clocks.
`default_nettype none
module adc_output_port_config
	import adc_port_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] d_in,
	output logic [15:0] d_out,
	output logic [15:0] d_oe,
	input wire logic cs_n,
	input wire logic sclk_in,
	output logic sclk_out,
	output logic sclk_oe,
	output logic frame_marker,
	output logic frame_marker_oe,
	output logic serial_result_out,
	output logic serial_result_oe,
	output logic busy
);
	function automatic logic [15:0] apply_coding(input logic [15:0] w, input logic straight);
		apply_coding = w ^ {~straight, 15'h0000};
	endfunction : apply_coding

	// Register bus
	port_cfg_t cfg;
	port_cfg_t next_cfg;
	logic [15:0] raw;
	logic [15:0] next_raw;
	logic [31:0] next_prdata;
	logic wr_access;
	logic mapped;
	logic start_req;

	// Conversion
	conv_mode_t mode;
	logic [5:0] conv_len;
	logic [5:0] conv_cnt;
	logic [5:0] next_conv_cnt;
	logic next_busy;
	logic [15:0] result_word;
	logic [15:0] next_result_word;
	logic [15:0] next_d_out;
	logic [15:0] coded;
	logic conv_start;
	logic conv_done;

	// Serial side
	logic [7:0] sync2;
	logic [7:0] sync3;
	logic [7:0] pin_lvl;
	logic [7:0] next_pin_lvl;
	serial_cfg_t scfg;
	logic cs_lvl;
	logic sclk_rise;
	logic daisy_chain_in;
	logic [1:0] eff_div;
	logic [2:0] half_len;
	ser_state_t state;
	ser_state_t next_state;
	logic [15:0] shreg;
	logic [15:0] next_shreg;
	logic [15:0] tx_word;
	logic [15:0] next_tx_word;
	logic [3:0] bit_cnt;
	logic [3:0] next_bit_cnt;
	logic [2:0] half_cnt;
	logic [2:0] next_half_cnt;
	logic sclk_lvl;
	logic next_sclk_lvl;
	logic next_frame_marker;
	logic pending;
	logic next_pending;
	logic trigger;
	logic take;

	always_comb begin
		mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_RAW) ||
			(paddr == ADDR_START) || (paddr == ADDR_STATUS);
		wr_access = psel && penable && pwrite && mapped;
		start_req = wr_access && (paddr == ADDR_START) && pwdata[START_GO_BIT];
		pready = 1'b1;
		pslverr = psel && penable && !mapped;
		next_cfg = cfg;
		next_raw = raw;
		if (wr_access && paddr == ADDR_CTRL) begin
			next_cfg = pwdata[4:0];
		end
		if (wr_access && paddr == ADDR_RAW) begin
			next_raw = pwdata[15:0];
		end
		next_prdata = prdata;
		if (psel && !penable) begin
			next_prdata = 32'h0000_0000;
			case (paddr)
				ADDR_CTRL: next_prdata[4:0] = cfg;
				ADDR_RAW: next_prdata[15:0] = raw;
				ADDR_STATUS: begin
					next_prdata[STAT_BUSY_BIT] = busy;
					next_prdata[STAT_MODE_LSB +: 3] = mode;
					next_prdata[STAT_STATE_LSB +: 3] = state;
					next_prdata[STAT_PENDING_BIT] = pending;
					next_prdata[STAT_DIV_LSB +: 2] = eff_div;
					next_prdata[STAT_CLKSRC_BIT] = scfg.clock_source_select;
					next_prdata[STAT_TIMING_BIT] = scfg.read_timing_select;
					next_prdata[STAT_POL_BIT] = scfg.frame_marker_polarity;
					next_prdata[STAT_RESULT_LSB +: 16] = coded;
				end
				default: next_prdata = 32'h0000_0000;
			endcase
		end
	end

	// Read data is captured in the setup phase so the access phase answers at once
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg <= CTRL_RESET;
			raw <= RAW_RESET;
			prdata <= 32'h0000_0000;
		end else begin
			cfg <= next_cfg;
			raw <= next_raw;
			prdata <= next_prdata;
		end
	end

	always_comb begin
		case ({cfg.fast_mode, cfg.rate_indep})
			2'b11: mode = MODE_WIDEBAND;
			2'b10: mode = MODE_FAST;
			default: mode = MODE_RATE_INDEP;
		endcase
		// Fastest modes share one conversion time; rate-independent mode takes the longer normal time
		conv_len = (mode == MODE_RATE_INDEP) ? 6'(CONV_NORMAL_CYCLES) : 6'(CONV_FAST_CYCLES);
		conv_start = start_req && !busy;
		conv_done = busy && (conv_cnt == 6'h00);
		next_busy = busy;
		next_conv_cnt = conv_cnt;
		next_result_word = result_word;
		if (conv_start) begin
			next_busy = 1'b1;
			next_conv_cnt = conv_len - 6'h01;
		end else if (conv_done) begin
			next_busy = 1'b0;
			next_result_word = raw;
		end else if (busy) begin
			next_conv_cnt = conv_cnt - 6'h01;
		end
		coded = apply_coding(result_word, cfg.output_coding_select);
		if (cfg.byte_order_select) begin
			next_d_out = {coded[7:0], coded[15:8]};
		end else begin
			next_d_out = coded;
		end
		// D0 and D1 are never turned around
		d_oe = cfg.iface_serial ? OE_SERIAL_MASK : OE_PARALLEL_MASK;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			conv_cnt <= 6'h00;
			result_word <= 16'h0000;
			d_out <= 16'h0000;
		end else begin
			busy <= next_busy;
			conv_cnt <= next_conv_cnt;
			result_word <= next_result_word;
			d_out <= next_d_out;
		end
	end

	pin_sync #(
		.WIDTH(8),
		.RESET_VALUE(PIN_LVL_RESET)
	) u_pin_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({sclk_in, cs_n, d_in[7:2]}),
		.q2(sync2),
		.q3(sync3)
	);

	always_comb begin
		// A pin level moves only once the last two stages agree
		next_pin_lvl = (sync2 & sync3) | (pin_lvl & (sync2 ^ sync3));
		sclk_rise = sync2[7] && sync3[7] && !pin_lvl[7];
		cs_lvl = pin_lvl[6];
		scfg.serial_clock_divider = {pin_lvl[PIN_DIV1 - 2], pin_lvl[PIN_DIV0 - 2]};
		scfg.clock_source_select = pin_lvl[PIN_CLK_SRC - 2];
		scfg.frame_marker_polarity = pin_lvl[PIN_POLARITY - 2];
		scfg.read_timing_select = pin_lvl[PIN_TIMING - 2];
		daisy_chain_in = pin_lvl[PIN_TIMING - 2];
		if (!scfg.clock_source_select && !scfg.read_timing_select) begin
			eff_div = scfg.serial_clock_divider;
		end else begin
			eff_div = 2'b00;
		end
		case (eff_div)
			2'b00: half_len = 3'(SCLK_HALF_0);
			2'b01: half_len = 3'(SCLK_HALF_1);
			2'b10: half_len = 3'(SCLK_HALF_2);
			default: half_len = 3'(SCLK_HALF_3);
		endcase
	end

	always_comb begin
		next_state = state;
		next_shreg = shreg;
		next_bit_cnt = bit_cnt;
		next_half_cnt = half_cnt;
		next_sclk_lvl = sclk_lvl;
		next_tx_word = tx_word;
		take = 1'b0;
		trigger = cfg.iface_serial && !scfg.clock_source_select &&
			(scfg.read_timing_select ? conv_start : conv_done);
		if (trigger) begin
			if (scfg.read_timing_select) begin
				next_tx_word = coded;
			end else begin
				next_tx_word = apply_coding(raw, cfg.output_coding_select);
			end
		end
		case (state)
			SER_IDLE: begin
				next_sclk_lvl = 1'b0;
				if (cfg.iface_serial && !scfg.clock_source_select && pending && !cs_lvl) begin
					next_state = SER_MASTER;
					take = 1'b1;
					next_shreg = tx_word;
					next_bit_cnt = 4'h0;
					next_half_cnt = half_len - 3'h1;
				end else if (cfg.iface_serial && scfg.clock_source_select && !cs_lvl) begin
					next_state = SER_SLAVE;
					next_shreg = coded;
				end
			end
			SER_MASTER: begin
				if (!cfg.iface_serial || cs_lvl) begin
					next_state = SER_IDLE;
				end else if (half_cnt == 3'h0) begin
					next_half_cnt = half_len - 3'h1;
					next_sclk_lvl = !sclk_lvl;
					// Data moves on the falling half so the host samples on the rise
					if (sclk_lvl) begin
						if (bit_cnt == 4'hf) begin
							next_state = SER_IDLE;
						end else begin
							next_shreg = {shreg[14:0], 1'b0};
							next_bit_cnt = bit_cnt + 4'h1;
						end
					end
				end else begin
					next_half_cnt = half_cnt - 3'h1;
				end
			end
			SER_SLAVE: begin
				if (!cfg.iface_serial || cs_lvl || !scfg.clock_source_select) begin
					next_state = SER_IDLE;
				end else if (sclk_rise) begin
					next_shreg = {shreg[14:0], daisy_chain_in};
				end
			end
			default: next_state = SER_IDLE;
		endcase
		// A new trigger in the same cycle as the take keeps the frame queued
		next_pending = (pending && !take) || trigger;
		next_frame_marker = (next_state == SER_MASTER) ^ scfg.frame_marker_polarity;
		sclk_oe = cfg.iface_serial && !scfg.clock_source_select;
		frame_marker_oe = sclk_oe;
		serial_result_oe = (state == SER_MASTER) || (state == SER_SLAVE);
		serial_result_out = shreg[15];
		sclk_out = sclk_lvl;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_lvl <= PIN_LVL_RESET;
			state <= SER_IDLE;
			shreg <= 16'h0000;
			tx_word <= 16'h0000;
			bit_cnt <= 4'h0;
			half_cnt <= 3'h0;
			sclk_lvl <= 1'b0;
			frame_marker <= 1'b0;
			pending <= 1'b0;
		end else begin
			pin_lvl <= next_pin_lvl;
			state <= next_state;
			shreg <= next_shreg;
			tx_word <= next_tx_word;
			bit_cnt <= next_bit_cnt;
			half_cnt <= next_half_cnt;
			sclk_lvl <= next_sclk_lvl;
			frame_marker <= next_frame_marker;
			pending <= next_pending;
		end
	end
endmodule : adc_output_port_config
`default_nettype wire

/* File: tb/adc_port_props.sv */
// Assertions on the output port configuration block
`default_nettype none
module adc_port_props
	import adc_port_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	input wire logic [15:0] d_oe,
	input wire logic sclk_oe,
	input wire logic frame_marker_oe,
	input wire logic serial_result_oe,
	input wire logic busy
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// Length of the current busy pulse, for an exact conversion time check
	logic [6:0] busy_len;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_len <= 7'h00;
		end else if (busy) begin
			busy_len <= busy_len + 7'h01;
		end else begin
			busy_len <= 7'h00;
		end
	end
	busy_len_a: assert property ($fell(busy) |-> busy_len == 7'(CONV_FAST_CYCLES)
		|| busy_len == 7'(CONV_NORMAL_CYCLES))
		else $error("conversion time not exact");
	low_lanes_a: assert property (d_oe[1:0] == 2'b11)
		else $error("low lanes not driven");
	lane_modes_a: assert property (d_oe == 16'hffff || d_oe == 16'h0003)
		else $error("bad lane enables");
	// The serial result enable follows the registered state, so it may lag a mode change by one cycle
	par_quiet_a: assert property (d_oe == 16'hffff [*3] |-> !sclk_oe && !serial_result_oe)
		else $error("serial pins active in parallel mode");
	marker_oe_a: assert property (frame_marker_oe == sclk_oe)
		else $error("marker enable differs from clock enable");
	start_busy_a: assert property (psel && penable && pwrite && paddr == ADDR_START
		&& pwdata[0] && !busy |=> busy)
		else $error("start did not raise busy");
	conv_len_a: assert property ($rose(busy) |-> busy [*8] ##[29:41] !busy)
		else $error("conversion length wrong");
	bad_addr_a: assert property (psel && penable && paddr > ADDR_STATUS |-> pslverr)
		else $error("unmapped access not refused");
	err_phase_a: assert property (pslverr |-> psel && penable)
		else $error("error outside access phase");
	cover property ($fell(busy));
	cover property (sclk_oe && serial_result_oe);
	cover property (!sclk_oe && serial_result_oe);
endmodule : adc_port_props
bind adc_output_port_config adc_port_props i_adc_port_props (.clk, .rst_n, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pslverr, .d_oe, .sclk_oe, .frame_marker_oe, .serial_result_oe,
	.busy);
`default_nettype wire

/* File: tb/adc_host_model.sv */
// Host model reading results over the serial port
`default_nettype none
module adc_host_model (
	input wire logic clk,
	output logic cs_n,
	output logic sclk_in,
	input wire logic sclk_out,
	input wire logic frame_marker,
	input wire logic serial_result_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cs_n = 1'b1;
		sclk_in = 1'b0;
	end
	// Levels held 5 cycles, since the device oversamples the host clock
	task automatic slave_read(output logic [31:0] b);
		cs_n <= 1'b0;
		repeat (8) @(posedge clk);
		for (int i = 31; i >= 0; i--) begin
			b[i] = serial_result_out;
			sclk_in <= 1'b1;
			repeat (5) @(posedge clk);
			sclk_in <= 1'b0;
			repeat (5) @(posedge clk);
		end
		cs_n <= 1'b1;
		repeat (8) @(posedge clk);
	endtask : slave_read
	// Samples on the device clock rising edge; per is -1 on timeout
	task automatic master_read(output logic [15:0] b, output int per, output logic mk);
		int n;
		int last;
		logic prev;
		cs_n <= 1'b0;
		mk = 1'b0;
		prev = 1'b0;
		n = 0;
		last = 0;
		per = 0;
		for (int i = 15; i >= 0; i--) begin
			while (n < 2000) begin
				@(posedge clk);
				n++;
				if (sclk_out === 1'b1 && prev === 1'b0) break;
				prev = sclk_out;
			end
			prev = 1'b1;
			b[i] = serial_result_out;
			if (i == 15) mk = frame_marker;
			if (i == 0) per = n - last;
			last = n;
		end
		if (n >= 2000) per = -1;
		cs_n <= 1'b1;
		repeat (8) @(posedge clk);
	endtask : master_read
endmodule : adc_host_model
`default_nettype wire

/* File: tb/tb_adc_output_port_config.sv */
// Self-checking bench for the output port configuration block
`default_nettype none
module tb_adc_output_port_config;
	timeunit 1ns;
	timeprecision 1ps;
	import adc_port_pkg::*;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, cs_n, sclk_in, perr, mk;
	logic sclk_out, sclk_oe, frame_marker, frame_marker_oe, busy;
	logic serial_result_out, serial_result_oe;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, bits;
	logic [15:0] d_in, d_out, d_oe, pin_drv, raw, cod, mb;
	int err_count, n_tests, per;
	// Pin level: the device wins where it drives
	assign d_in = (d_oe & d_out) | (~d_oe & pin_drv);
	adc_output_port_config i_adc_output_port_config (.clk, .rst_n, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .d_in, .d_out, .d_oe, .cs_n, .sclk_in,
		.sclk_out, .sclk_oe, .frame_marker, .frame_marker_oe, .serial_result_out,
		.serial_result_oe, .busy);
	adc_host_model i_adc_host_model (.clk, .cs_n, .sclk_in, .sclk_out, .frame_marker,
		.serial_result_out);
	task automatic test_done();
		if (err_count == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : test_done
	task automatic tmo();
		err_count++;
		test_done();
	endtask : tmo
	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", w, e, g);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) tmo();
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic convert();
		int n;
		apb(1'b1, ADDR_START, 32'h1);
		@(posedge clk);
		chk("busy", 32'h1, busy);
		n = 0;
		while (busy !== 1'b0 && n < 100) begin
			@(posedge clk);
			n++;
		end
		if (n >= 100) tmo();
		repeat (3) @(posedge clk);
	endtask : convert
	function automatic logic [2:0] mode(input logic f, input logic r);
		return (f && r) ? 3'b001 : f ? 3'b010 : 3'b100;
	endfunction : mode
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata, pin_drv} = '0;
		err_count = 0;
		n_tests = 0;
		void'($urandom(32'h595f68dd));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		chk("oe", 16'hffff, d_oe);
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl", 32'h2, rd);
		apb(1'b0, 8'h10, 32'h0);
		chk("err", 32'h1, perr);
		apb(1'b1, 8'hfc, 32'hffffffff);
		chk("err", 32'h1, perr);
		// Every lane order, coding and mode; starts kept frequent
		for (int i = 0; i < 16; i++) begin
			raw = (i == 0) ? 16'h8000 : (i == 1) ? 16'h7fff : 16'($urandom);
			apb(1'b1, ADDR_RAW, {16'h0, raw});
			apb(1'b1, ADDR_CTRL, 32'(i));
			convert();
			cod = i[1] ? raw : raw ^ 16'h8000;
			chk("d_out", i[0] ? {cod[7:0], cod[15:8]} : cod, d_out);
			apb(1'b0, ADDR_STATUS, 32'h0);
			chk("mode", mode(i[2], i[3]), rd[3:1]);
			chk("coded", cod, rd[31:16]);
		end
		// Slave read with daisy level high; pins held for the whole read
		pin_drv <= {8'($urandom), 8'h90};
		raw = 16'($urandom);
		apb(1'b1, ADDR_RAW, {16'h0, raw});
		apb(1'b1, ADDR_CTRL, 32'h12);
		#1;
		chk("oe", 16'h0003, d_oe);
		convert();
		i_adc_host_model.slave_read(bits);
		chk("slave", {raw, 16'hffff}, bits);
		// Master read after convert, slowest divider, active-low marker
		pin_drv <= {8'($urandom), 8'h2c};
		repeat (8) @(posedge clk);
		chk("sclk_oe", 32'h1, sclk_oe);
		chk("marker", 32'h1, frame_marker);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("div", 32'h3, rd[9:8]);
		convert();
		i_adc_host_model.master_read(mb, per, mk);
		if (per < 0) tmo();
		chk("master", raw, mb);
		chk("period", 2 * SCLK_HALF_3, per);
		chk("marker_act", 32'h0, mk);
		// Master read during convert: previous result, divider ignored, active-high marker
		pin_drv <= {8'($urandom), 8'h8c};
		repeat (8) @(posedge clk);
		chk("marker", 32'h0, frame_marker);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("div", 32'h0, rd[9:8]);
		cod = 16'($urandom);
		apb(1'b1, ADDR_RAW, {16'h0, cod});
		convert();
		i_adc_host_model.master_read(mb, per, mk);
		if (per < 0) tmo();
		chk("previous", raw, mb);
		chk("period", 2 * SCLK_HALF_0, per);
		chk("marker_act", 32'h1, mk);
		test_done();
	end
endmodule : tb_adc_output_port_config
`default_nettype wire
